/* common/mlp_pkg.sv */
// Constants, types and decode helpers for the serial protocol front end.
// Assumes a 100 MHz system clock and a host that drives the serial clock.
package mlp_pkg;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MLP_EXT = 2'b00, MLP_DUAL = 2'b01, MLP_QUAD = 2'b11} mlp_proto_t;
    typedef enum logic [1:0] {MLP_CMD = 2'b00, MLP_ARG = 2'b01, MLP_OUT = 2'b11, MLP_SKIP = 2'b10} mlp_spi_t;

    // ------------------------------------------------------------
    // Serial commands
    // ------------------------------------------------------------
    localparam logic [7:0] MLP_OP_RD_STATUS = 8'h05;
    localparam logic [7:0] MLP_OP_WR_EVCR = 8'h61;
    localparam logic [7:0] MLP_OP_WR_NVCR = 8'hB1;
    localparam logic [7:0] MLP_OP_RESCUE = 8'hFF;

    // ------------------------------------------------------------
    // Configuration fields and reset values
    // ------------------------------------------------------------
    localparam int MLP_EV_DUAL_BIT = 6;
    localparam int MLP_EV_QUAD_BIT = 7;
    localparam int MLP_NV_DUAL_BIT = 2;
    localparam int MLP_NV_QUAD_BIT = 3;
    localparam logic [15:0] MLP_NVCR_RESET = 16'hFFFF;
    localparam logic [7:0] MLP_EVCR_RESET = 8'hFF;

    // ------------------------------------------------------------
    // Register map and status fields
    // ------------------------------------------------------------
    localparam logic [3:0] MLP_REG_NVCR = 4'h0;
    localparam logic [3:0] MLP_REG_STATUS = 4'h4;
    localparam logic [3:0] MLP_REG_EVCR = 4'h8;
    localparam logic [3:0] MLP_REG_LASTCMD = 4'hC;
    localparam int MLP_ST_WIP = 0;
    localparam int MLP_ST_PROTO = 1;
    localparam int MLP_ST_EFF = 3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int MLP_CLK_PERIOD_NS = 10;
    localparam int MLP_NVW_TIME_NS = 10000;
    localparam int MLP_NVW_CYCLES = MLP_NVW_TIME_NS / MLP_CLK_PERIOD_NS;

    // Protocol chosen by a volatile configuration value.
    function automatic mlp_proto_t mlp_ev_proto(input logic [7:0] ev);
        if (!ev[MLP_EV_QUAD_BIT]) begin
            return MLP_QUAD;
        end else if (!ev[MLP_EV_DUAL_BIT]) begin
            return MLP_DUAL;
        end
        return MLP_EXT;
    endfunction

    // Protocol chosen at power-on by the nonvolatile configuration.
    function automatic mlp_proto_t mlp_nv_proto(input logic [15:0] nv);
        if (!nv[MLP_NV_QUAD_BIT]) begin
            return MLP_QUAD;
        end else if (!nv[MLP_NV_DUAL_BIT]) begin
            return MLP_DUAL;
        end
        return MLP_EXT;
    endfunction

endpackage

/* rtl/mlp_serial_front.sv */
// Serial interface front end with extended, dual and quad lane protocols.
// Assumes a host driving sck and csN, and a core reporting program or erase activity.
//
// Functional notes
// - Inputs sampled on rising serial clock; outputs change on falling serial clock.
// - Clock modes 0 and 3 only; idle clock level is the host's choice.
// - Both clock modes behave identically in every protocol.
// - Unselected device keeps every output lane in high impedance.
// - Default protocol is extended; command byte arrives on io_line_0 alone.
// - Volatile write with bit 6 low, bit 7 high selects two lanes.
// - Volatile write with bit 7 low selects four lanes.
// - Volatile protocol choice is lost at power-on.
// - Rescue sequence or volatile write with bits 6 and 7 high returns to default protocol.
// - Nonvolatile bit 2 low, bit 3 high makes every power-on start in dual protocol.
// - Nonvolatile bit 3 low makes every power-on start in quad protocol.
// - Quad protocol uses four lanes for every phase.
// - Quad protocol falls back to extended during high-voltage program or erase.
// - Boot loads the working protocol from nonvolatile configuration.
// - Status bit 0 shows write, program or erase in progress.
module mlp_serial_front #(
    parameter int NV_WRITE_CYCLES = mlp_pkg::MLP_NVW_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic nvFactoryRst,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    input wire logic progEraseBusy,
    input wire logic vppHigh,
    output mlp_pkg::mlp_proto_t laneMode,
    input wire logic sck,
    input wire logic csN,
    input wire logic [3:0] ioIn,
    output logic [3:0] ioOut,
    output logic [3:0] ioOe
);
    import mlp_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    mlp_spi_t spiStateQ;
    mlp_proto_t laneQ, protoQ, effProtoQ;
    logic [2:0] bitCntQ, outIdxQ, step;
    logic [3:0] bitSum;
    logic [7:0] shiftQ, shiftD, cmdQ, statusByte, outBits;
    logic argCntQ, byteDone;
    logic [3:0] tglQ, tglMeta, tglSync, tglSeen, tglEvt;
    logic [7:0] evcrDataQ, cmdDataQ, evcrQ, lastCmdQ;
    logic [15:0] nvDataQ, nvcfgQ;
    logic wipMeta, wipSync, vppMeta, vppSync, bootQ, hvFallback, wip, nvStart;
    logic [15:0] nvCntQ;
    logic [3:0] ioOutQ, oeQ;
    logic [31:0] rdD;

    // ------------------------------------------------------------
    // Serial input shifting
    // ------------------------------------------------------------
    always_comb begin
        unique case (laneQ)
            MLP_QUAD: begin
                step = 3'd4;
                shiftD = {shiftQ[3:0], ioIn[3:0]};
            end
            MLP_DUAL: begin
                step = 3'd2;
                shiftD = {shiftQ[5:0], ioIn[1:0]};
            end
            default: begin
                step = 3'd1;
                shiftD = {shiftQ[6:0], ioIn[0]};
            end
        endcase
        bitSum = {1'b0, bitCntQ} + {1'b0, step};
        byteDone = (spiStateQ == MLP_CMD || spiStateQ == MLP_ARG) && bitSum == 4'h8;
    end

    // Lane width is frozen for the whole frame at its start.
    always_ff @(negedge csN) begin
        laneQ <= effProtoQ;
    end

    // Frame state; chip select high clears it without a clock.
    always_ff @(posedge sck or posedge csN) begin
        if (csN) begin
            spiStateQ <= MLP_CMD;
            bitCntQ <= 3'd0;
            shiftQ <= 8'h00;
            cmdQ <= 8'h00;
            argCntQ <= 1'b0;
            outIdxQ <= 3'd0;
        end else begin
            shiftQ <= shiftD;
            bitCntQ <= bitSum[2:0];
            unique case (spiStateQ)
                MLP_CMD: begin
                    if (byteDone) begin
                        cmdQ <= shiftD;
                        unique case (shiftD)
                            MLP_OP_RD_STATUS: spiStateQ <= MLP_OUT;
                            MLP_OP_WR_EVCR, MLP_OP_WR_NVCR: spiStateQ <= MLP_ARG;
                            default: spiStateQ <= MLP_SKIP;
                        endcase
                    end
                end
                MLP_ARG: begin
                    if (byteDone) begin
                        argCntQ <= 1'b1;
                        if (cmdQ == MLP_OP_WR_EVCR || argCntQ) begin
                            spiStateQ <= MLP_SKIP;
                        end
                    end
                end
                MLP_OUT: begin
                    outIdxQ <= outIdxQ + step;
                end
                MLP_SKIP: begin
                end
            endcase
        end
    end

    // Completed writes are posted to the system clock as toggles with held data.
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            tglQ <= 4'h0;
            evcrDataQ <= MLP_EVCR_RESET;
            nvDataQ <= MLP_NVCR_RESET;
            cmdDataQ <= 8'h00;
        end else if (byteDone && !csN) begin
            if (spiStateQ == MLP_CMD) begin
                cmdDataQ <= shiftD;
                tglQ[3] <= ~tglQ[3];
                if (shiftD == MLP_OP_RESCUE) begin
                    tglQ[2] <= ~tglQ[2];
                end
            end else if (cmdQ == MLP_OP_WR_EVCR) begin
                evcrDataQ <= shiftD;
                tglQ[0] <= ~tglQ[0];
            end else if (!argCntQ) begin
                nvDataQ[7:0] <= shiftD;
            end else begin
                nvDataQ[15:8] <= shiftD;
                tglQ[1] <= ~tglQ[1];
            end
        end
    end

    // Busy flag brought onto the serial clock for status reads.
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            wipMeta <= 1'b0;
            wipSync <= 1'b0;
        end else begin
            wipMeta <= wip;
            wipSync <= wipMeta;
        end
    end

    // ------------------------------------------------------------
    // Serial output on the falling edge
    // ------------------------------------------------------------
    assign statusByte = {7'h00, wipSync};
    assign outBits = statusByte << outIdxQ;

    always_ff @(negedge sck or posedge csN) begin
        if (csN) begin
            ioOutQ <= 4'h0;
            oeQ <= 4'h0;
        end else if (spiStateQ == MLP_OUT) begin
            unique case (laneQ)
                MLP_QUAD: begin
                    ioOutQ <= outBits[7:4];
                    oeQ <= 4'hF;
                end
                MLP_DUAL: begin
                    ioOutQ <= {2'b00, outBits[7:6]};
                    oeQ <= 4'h3;
                end
                default: begin
                    ioOutQ <= {2'b00, outBits[7], 1'b0};
                    oeQ <= 4'h2;
                end
            endcase
        end else begin
            oeQ <= 4'h0;
        end
    end

    assign ioOut = ioOutQ;
    assign ioOe = oeQ & {4{~csN}};

    // ------------------------------------------------------------
    // System clock synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            tglMeta <= 4'h0;
            tglSync <= 4'h0;
            tglSeen <= 4'h0;
            vppMeta <= 1'b0;
            vppSync <= 1'b0;
        end else begin
            tglMeta <= tglQ;
            tglSync <= tglMeta;
            tglSeen <= tglSync;
            vppMeta <= vppHigh;
            vppSync <= vppMeta;
        end
    end

    assign tglEvt = tglSync ^ tglSeen;

    // ------------------------------------------------------------
    // Configuration registers and protocol selection
    // ------------------------------------------------------------
    assign nvStart = tglEvt[1] || (regWr && regAddr == MLP_REG_NVCR);

    // Nonvolatile contents survive the power-on reset.
    always_ff @(posedge clock) begin
        if (nvFactoryRst) begin
            nvcfgQ <= MLP_NVCR_RESET;
        end else if (tglEvt[1]) begin
            nvcfgQ <= nvDataQ;
        end else if (regWr && regAddr == MLP_REG_NVCR) begin
            nvcfgQ <= regWrData[15:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            nvCntQ <= 16'h0000;
        end else if (nvStart) begin
            nvCntQ <= 16'(NV_WRITE_CYCLES);
        end else if (nvCntQ != 16'h0000) begin
            nvCntQ <= nvCntQ - 16'h0001;
        end
    end

    assign wip = progEraseBusy || nvCntQ != 16'h0000;

    always_ff @(posedge clock) begin
        if (rst) begin
            evcrQ <= MLP_EVCR_RESET;
            lastCmdQ <= 8'h00;
        end else begin
            if (tglEvt[0]) begin
                evcrQ <= evcrDataQ;
            end else if (regWr && regAddr == MLP_REG_EVCR) begin
                evcrQ <= regWrData[7:0];
            end
            if (tglEvt[3]) begin
                lastCmdQ <= cmdDataQ;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            protoQ <= MLP_EXT;
            bootQ <= 1'b1;
        end else begin
            bootQ <= 1'b0;
            if (bootQ) begin
                protoQ <= mlp_nv_proto(nvcfgQ);
            end else if (tglEvt[2]) begin
                protoQ <= MLP_EXT;
            end else if (tglEvt[0]) begin
                protoQ <= mlp_ev_proto(evcrDataQ);
            end else if (regWr && regAddr == MLP_REG_EVCR) begin
                protoQ <= mlp_ev_proto(regWrData[7:0]);
            end
        end
    end

    assign hvFallback = protoQ == MLP_QUAD && vppSync && progEraseBusy;

    always_ff @(posedge clock) begin
        if (rst) begin
            effProtoQ <= MLP_EXT;
        end else begin
            effProtoQ <= hvFallback ? MLP_EXT : protoQ;
        end
    end

    assign laneMode = effProtoQ;

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    always_comb begin
        rdD = 32'h0000_0000;
        unique case (regAddr)
            MLP_REG_NVCR: rdD[15:0] = nvcfgQ;
            MLP_REG_STATUS: begin
                rdD[MLP_ST_WIP] = wip;
                rdD[MLP_ST_PROTO +: 2] = protoQ;
                rdD[MLP_ST_EFF +: 2] = effProtoQ;
            end
            MLP_REG_EVCR: rdD[7:0] = evcrQ;
            MLP_REG_LASTCMD: rdD[7:0] = lastCmdQ;
            default: rdD = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            regRdData <= 32'h0000_0000;
        end else begin
            regRdData <= regRd ? rdD : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence evcrDual;
        tglEvt[0] && !tglEvt[2] && !bootQ && evcrDataQ[7:6] == 2'b10;
    endsequence

    sequence evcrQuad;
        tglEvt[0] && !tglEvt[2] && !bootQ && !evcrDataQ[7];
    endsequence

    a_boot_load: assert property (bootQ |=> protoQ == mlp_nv_proto($past(nvcfgQ)))
        else $error("boot did not load protocol from nonvolatile configuration");
    a_boot_quad: assert property (bootQ && !nvcfgQ[MLP_NV_QUAD_BIT] |=> protoQ == MLP_QUAD
        ##1 effProtoQ == ($past(hvFallback) ? MLP_EXT : MLP_QUAD))
        else $error("quad power-on choice ignored");
    a_evcr_dual: assert property (evcrDual |=> protoQ == MLP_DUAL ##1 effProtoQ == MLP_DUAL)
        else $error("dual protocol not entered after volatile write");
    a_evcr_quad: assert property (evcrQuad |=> protoQ == MLP_QUAD)
        else $error("quad protocol not entered after volatile write");
    a_rescue_ext: assert property (tglEvt[2] && !bootQ |=> protoQ == MLP_EXT)
        else $error("rescue did not restore extended protocol");
    a_hv_fallback: assert property (hvFallback |=> effProtoQ == MLP_EXT)
        else $error("no extended fall-back during high-voltage operation");
    a_quad_resume: assert property (protoQ == MLP_QUAD && !hvFallback |=> effProtoQ == MLP_QUAD || $changed(protoQ))
        else $error("quad protocol not resumed");
    a_wip_busy: assert property (nvStart |=> wip [*8])
        else $error("write in progress flag dropped early");
    a_hiz_unsel: assert property (csN |-> ioOe == 4'h0)
        else $error("unselected device drives an output lane");
    a_cmd_restart: assert property (@(posedge sck) disable iff (csN)
        $rose(spiStateQ == MLP_OUT) |-> outIdxQ == 3'd0 && cmdQ == MLP_OP_RD_STATUS)
        else $error("output phase did not start at first bit");

endmodule // mlp_serial_front

/* tb/mlp_host_model.sv */
// Host model that drives the serial clock, chip select and input lanes of the front end.
// Assumes the testbench calls its tasks one frame at a time; the serial clock stops between frames.
module mlp_host_model (
    output logic sck,
    output logic csN,
    output logic [3:0] ioIn,
    input wire logic [3:0] ioOut,
    input wire logic [3:0] ioOe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic idleLvl;

    initial begin
        idleLvl = 1'b0;
        sck = 1'b0;
        csN = 1'b1;
        ioIn = 4'h5;
    end

    // ------------------------------------------------------------
    // Serial clock and framing
    // ------------------------------------------------------------
    // One 30 ns clock; lanes outside the mask toggle so a stale value is never seen.
    task automatic clockBit(input logic [3:0] d, input int lanes, output logic [3:0] q, output logic [3:0] oe);
        logic [3:0] mask;
        mask = 4'((1 << lanes) - 1);
        sck = 1'b0;
        #2;
        ioIn = (d & mask) | (~ioIn & ~mask);
        #13;
        sck = 1'b1;
        q = (ioOut & ioOe) | (~ioOut & ~ioOe);
        oe = ioOe;
        #15;
    endtask

    task automatic beginFrame(input logic mode);
        idleLvl = mode;
        sck = mode;
        #7;
        csN = 1'b0;
        #20;
    endtask

    task automatic endFrame();
        if (!idleLvl) begin
            #2;
            sck = 1'b0;
        end
        #13;
        csN = 1'b1;
        ioIn = ~ioIn;
        #53;
    endtask

    task automatic putByte(input logic [7:0] b, input int lanes);
        logic [3:0] q;
        logic [3:0] oe;
        for (int s = 0; s < 8 / lanes; s++) begin
            clockBit(4'(b >> (8 - lanes * (s + 1))), lanes, q, oe);
        end
    endtask

    task automatic getByte(input int lanes, output logic [7:0] b, output logic [3:0] oe);
        logic [3:0] q;
        b = 8'h00;
        for (int s = 0; s < 8 / lanes; s++) begin
            clockBit(4'h0, 0, q, oe);
            b = (lanes == 1) ? {b[6:0], q[1]} : (lanes == 2) ? {b[5:0], q[1:0]} : {b[3:0], q};
        end
    endtask
endmodule // mlp_host_model

/* tb/testbench.sv */
// Self-checking testbench of the serial protocol front end.
// Assumes the host model drives the serial side and the bench drives the register bus.
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin failures++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import mlp_pkg::*;
    localparam int NVW = 16;
    logic clock, rst, nvFactoryRst, regWr, regRd, progEraseBusy, vppHigh, sck, csN;
    logic [3:0] regAddr, ioIn, ioOut, ioOe, q4, oe4;
    logic [31:0] regWrData, regRdData, rd;
    logic [7:0] v;
    mlp_proto_t laneMode, expProto;
    int failures, tests_run;

    mlp_serial_front #(.NV_WRITE_CYCLES(NVW)) dut_u (.clock(clock), .rst(rst), .nvFactoryRst(nvFactoryRst),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .progEraseBusy(progEraseBusy), .vppHigh(vppHigh), .laneMode(laneMode), .sck(sck), .csN(csN),
        .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));
    mlp_host_model host_u (.sck(sck), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Expectations and bus tasks
    // ------------------------------------------------------------
    function automatic mlp_proto_t benchProto(input logic [7:0] ev);
        if (ev[7] === 1'b0) return MLP_QUAD;
        if (ev[6] === 1'b0) return MLP_DUAL;
        return MLP_EXT;
    endfunction

    function automatic int lanesOf(input mlp_proto_t p);
        return (p == MLP_QUAD) ? 4 : (p == MLP_DUAL) ? 2 : 1;
    endfunction

    task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask

    task automatic regRead(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask

    task automatic doReset();
        @(posedge clock);
        rst <= 1'b1;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    task automatic spiCmd(input logic mode, input logic [7:0] op, input int n, input logic [15:0] arg);
        host_u.beginFrame(mode);
        host_u.putByte(op, lanesOf(expProto));
        for (int i = 0; i < n; i++) begin
            host_u.putByte(arg[8*i +: 8], lanesOf(expProto));
        end
        host_u.endFrame();
        repeat (10) @(posedge clock);
    endtask

    task automatic spiStatus(input logic mode, input logic wip);
        logic [7:0] b;
        logic [3:0] oe;
        host_u.beginFrame(mode);
        host_u.putByte(MLP_OP_RD_STATUS, lanesOf(expProto));
        for (int i = 0; i < 2; i++) begin
            host_u.getByte(lanesOf(expProto), b, oe);
            `CHK("status byte", {7'h00, wip}, b);
            `CHK("lane enables", (expProto == MLP_QUAD) ? 4'hF : (expProto == MLP_DUAL) ? 4'h3 : 4'h2, oe);
        end
        host_u.endFrame();
        `CHK("enables idle", 4'h0, ioOe);
    endtask

    task automatic report_and_stop();
        $display("Checks made %0d, errors %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #400000;
        failures++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, nvFactoryRst, regWr, regRd, progEraseBusy, vppHigh} = 6'b110000;
        regAddr = 4'h0;
        regWrData = 32'h0;
        failures = 0;
        tests_run = 0;
        expProto = MLP_EXT;
        void'($urandom(32'hF42899A6));
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        nvFactoryRst <= 1'b0;
        repeat (6) @(posedge clock);
        `CHK("boot mode", MLP_EXT, laneMode);
        `CHK("enables idle", 4'h0, ioOe);
        regRead(MLP_REG_NVCR, rd);
        `CHK("nvcr reset", 32'h0000FFFF, rd);
        regRead(MLP_REG_EVCR, rd);
        `CHK("evcr reset", 8'hFF, rd[7:0]);
        regRead(4'h2, rd);
        `CHK("unmapped read", 32'h0, rd);
        regWrite(MLP_REG_STATUS, 32'hFFFFFFFF);
        regRead(MLP_REG_STATUS, rd);
        `CHK("status ro", 3'b000, {rd[4:3], rd[0]});
        spiStatus(1'b0, 1'b0);
        spiStatus(1'b1, 1'b0);
        @(posedge clock);
        progEraseBusy <= 1'b1;
        spiStatus(1'b0, 1'b1);
        @(posedge clock);
        progEraseBusy <= 1'b0;
        host_u.beginFrame(1'b0);
        repeat (3) host_u.clockBit(4'h1, 1, q4, oe4);
        host_u.endFrame();
        spiStatus(1'b0, 1'b0);
        for (int m = 0; m < 2; m++) begin
            v = (8'($urandom) & 8'hBF) | 8'h80;
            spiCmd(1'(m), MLP_OP_WR_EVCR, 1, {8'h00, v});
            expProto = benchProto(v);
            `CHK("dual mode", MLP_DUAL, laneMode);
            spiStatus(1'(m), 1'b0);
            v = 8'($urandom) & 8'h7F;
            spiCmd(1'(m), MLP_OP_WR_EVCR, 1, {8'h00, v});
            expProto = benchProto(v);
            `CHK("quad mode", MLP_QUAD, laneMode);
            spiStatus(1'(m), 1'b0);
            v = 8'($urandom) | 8'hC0;
            spiCmd(1'(m), MLP_OP_WR_EVCR, 1, {8'h00, v});
            expProto = benchProto(v);
            `CHK("write to ext", MLP_EXT, laneMode);
            expProto = MLP_QUAD;
            regWrite(MLP_REG_EVCR, 32'h7F);
            repeat (4) @(posedge clock);
            spiCmd(1'(m), MLP_OP_RESCUE, 0, 16'h0);
            expProto = MLP_EXT;
            `CHK("rescue", MLP_EXT, laneMode);
            regRead(MLP_REG_LASTCMD, rd);
            `CHK("last command", MLP_OP_RESCUE, rd[7:0]);
            spiStatus(1'(m), 1'b0);
        end
        regWrite(MLP_REG_EVCR, 32'h7F);
        @(posedge clock);
        vppHigh <= 1'b1;
        progEraseBusy <= 1'b1;
        repeat (6) @(posedge clock);
        `CHK("vpp fallback", MLP_EXT, laneMode);
        spiStatus(1'b0, 1'b1);
        @(posedge clock);
        vppHigh <= 1'b0;
        repeat (6) @(posedge clock);
        `CHK("vpp resume", MLP_QUAD, laneMode);
        progEraseBusy <= 1'b0;
        expProto = MLP_QUAD;
        spiStatus(1'b1, 1'b0);
        repeat (8) begin
            v = 8'($urandom);
            regWrite(MLP_REG_EVCR, {24'h0, v});
            repeat (3) @(posedge clock);
            `CHK("random mode", benchProto(v), laneMode);
            regRead(MLP_REG_EVCR, rd);
            `CHK("evcr value", v, rd[7:0]);
        end
        regWrite(MLP_REG_NVCR, 32'h0000FFFB);
        regRead(MLP_REG_STATUS, rd);
        `CHK("nv busy", 1'b1, rd[0]);
        repeat (NVW + 8) @(posedge clock);
        regRead(MLP_REG_STATUS, rd);
        `CHK("nv done", 1'b0, rd[0]);
        doReset();
        expProto = MLP_DUAL;
        `CHK("nv dual boot", MLP_DUAL, laneMode);
        regRead(MLP_REG_EVCR, rd);
        `CHK("evcr lost", 8'hFF, rd[7:0]);
        spiStatus(1'b0, 1'b0);
        spiCmd(1'b1, MLP_OP_WR_NVCR, 2, 16'hFFF7);
        repeat (NVW + 8) @(posedge clock);
        doReset();
        expProto = MLP_QUAD;
        `CHK("nv quad boot", MLP_QUAD, laneMode);
        spiStatus(1'b1, 1'b0);
        @(posedge clock);
        nvFactoryRst <= 1'b1;
        @(posedge clock);
        nvFactoryRst <= 1'b0;
        doReset();
        `CHK("factory boot", MLP_EXT, laneMode);
        report_and_stop();
    end
endmodule // testbench
